//--- rtcp_in_filter.sv
`timescale 1ns/1ps
`default_nettype none
module rtcp_in_filter
	import rtcp_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_pin,
	input  wire logic       i_enable,
	input  wire logic [2:0] i_sel,
	output logic            o_level
);
	logic       s1_r;
	logic       s2_r;
	logic       lvl_r;
	logic       lvl_nxt;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] lim;

	// input must stay at a new level for 2^sel cycles before it is taken
	always_comb
	begin
		lim     = 8'((9'h001 << i_sel) - 9'h001);
		lvl_nxt = lvl_r;
		cnt_nxt = 8'h00;
		if (!i_enable)
			lvl_nxt = s2_r;
		else if (s2_r != lvl_r)
		begin
			if (cnt_r == lim)
				lvl_nxt = s2_r;
			else
				cnt_nxt = cnt_r + 8'h01;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			s1_r  <= 1'b0;
			s2_r  <= 1'b0;
			lvl_r <= 1'b0;
			cnt_r <= 8'h00;
		end
		else
		begin
			s1_r  <= i_pin;
			s2_r  <= s1_r;
			lvl_r <= lvl_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign o_level = lvl_r;
endmodule
`default_nettype wire

//--- rtcp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtcp_pin_model
(
	input  wire logic i_core_clk,
	input  wire logic i_rstn,
	input  wire logic i_level,
	output logic      o_pin
);
	logic [1:0] gap_r;
	// edges on the pin stay at least four clocks apart
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_pin <= 1'b0;
			gap_r <= 2'h0;
		end
		else if (i_level != o_pin && gap_r == 2'h3)
		begin
			o_pin <= i_level;
			gap_r <= 2'h0;
		end
		else if (gap_r != 2'h3)
			gap_r <= gap_r + 2'h1;
	end
endmodule
`default_nettype wire

//--- rtcp_pkg.sv
`default_nettype none
package rtcp_pkg;
	// register byte addresses, one aligned word each, data in bits [7:0]
	localparam logic [5:0] REG_CNT_HI  = 6'h00;
	localparam logic [5:0] REG_CNT_LO  = 6'h04;
	localparam logic [5:0] REG_RLD_HI  = 6'h08;
	localparam logic [5:0] REG_RLD_LO  = 6'h0c;
	localparam logic [5:0] REG_CHA_HI  = 6'h10;
	localparam logic [5:0] REG_CHA_LO  = 6'h14;
	localparam logic [5:0] REG_CHB_HI  = 6'h18;
	localparam logic [5:0] REG_CHB_LO  = 6'h1c;
	localparam logic [5:0] REG_CTL0    = 6'h20;
	localparam logic [5:0] REG_CTL1    = 6'h24;
	localparam logic [5:0] REG_CTL2    = 6'h28;
	localparam logic [5:0] REG_NFC     = 6'h2c;

	// timer_control_zero fields
	localparam int CTL0_MODE_EXT  = 7;
	localparam int CTL0_ISEL_HI   = 4;
	localparam int CTL0_ISEL_LO   = 3;
	// timer_control_one fields
	localparam int CTL1_RUN       = 7;
	localparam int CTL1_POL       = 6;
	localparam int CTL1_PRE_HI    = 5;
	localparam int CTL1_PRE_LO    = 3;
	localparam int CTL1_MODE_HI   = 2;
	// timer_control_two fields
	localparam int CTL2_DUAL_EDGE = 4;
	localparam int CTL2_OUT_EN    = 1;
	localparam int CTL2_CLK_SEL   = 0;
	// noise filter control fields
	localparam int NFC_EN         = 7;
	localparam int NFC_SEL_HI     = 6;
	localparam int NFC_SEL_LO     = 4;

	// {mode_extension_bit, mode field}
	localparam logic [3:0] MODE_CONT  = 4'h1;
	localparam logic [3:0] MODE_PWM   = 4'h3;
	localparam logic [3:0] MODE_TRIG  = 4'h7;
	localparam logic [3:0] MODE_DEMOD = 4'hc;

	// interrupt_source_select values
	localparam logic [1:0] ISEL_CAP_ONLY = 2'h2;
	localparam logic [1:0] ISEL_RLD_ONLY = 2'h3;

	localparam logic [15:0] CNT_RESTART = 16'h0001;
	localparam logic [7:0]  CTL_RESET   = 8'h00;
	localparam logic [15:0] CNT_RESET   = 16'h0001;
	localparam logic [15:0] WORD_RESET  = 16'h0000;

	typedef enum logic {RUN_WAIT, RUN_COUNT} rtcp_run_type;
endpackage
`default_nettype wire

//--- rtcp_timer.sv
// Summary of operation
// - 16-bit counter behind 1..128 prescaler
// - capture/compare channel a and capture-only channel b share one counter
// - counts in the four defined modes on either clock
// - one-shot: count, pulse output, await trigger
// - continuous: hit reload, interrupt, restart 0001H
// - continuous: toggle output on reload when enabled
// - start count first pass only, then 0001H
// - pwm polarity 1: high, low at compare
// - pwm polarity 0: low, high at compare
// - clock source chosen in control two
// - demodulation uses mode field plus extension bit
// - capture edge by polarity, or both edges
// - demodulation interrupt: both, capture or reload
// - demodulation waits for first input transition
// - optional tunable noise filter on input
// - capture stores counter value in channel
// - high-byte read latches low byte while running
// - reload high byte buffered until low write
`timescale 1ns/1ps
`default_nettype none
module rtcp_timer
	import rtcp_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	input  wire logic [5:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	input  wire logic        i_timer_in,
	input  wire logic        i_sec_osc,
	output logic             o_timer_out,
	output logic             o_irq
);
	// bus state
	logic         wait_r;
	logic         wait_nxt;
	logic [7:0]   rdata_r;
	logic [7:0]   rdata_nxt;
	// timer state
	logic [15:0]  cnt_r;
	logic [15:0]  cnt_nxt;
	logic [15:0]  rld_r;
	logic [15:0]  rld_nxt;
	logic [7:0]   rld_hold_r;
	logic [7:0]   rld_hold_nxt;
	logic [7:0]   cnt_hold_r;
	logic [7:0]   cnt_hold_nxt;
	logic [15:0]  cha_r;
	logic [15:0]  cha_nxt;
	logic [15:0]  chb_r;
	logic [15:0]  chb_nxt;
	logic [7:0]   ctl0_r;
	logic [7:0]   ctl0_nxt;
	logic [7:0]   ctl1_r;
	logic [7:0]   ctl1_nxt;
	logic [7:0]   ctl2_r;
	logic [7:0]   ctl2_nxt;
	logic [7:0]   nfc_r;
	logic [7:0]   nfc_nxt;
	logic [6:0]   pre_r;
	logic [6:0]   pre_nxt;
	logic         lvl_r;
	logic         lvl_nxt;
	logic         tout_r;
	logic         tout_nxt;
	logic         irq_r;
	logic         irq_nxt;
	logic         in_prev_r;
	logic         sec_s1_r;
	logic         sec_s2_r;
	logic         sec_prev_r;
	rtcp_run_type run_r;
	rtcp_run_type run_nxt;
	// combinational helpers
	logic         fin;
	logic         acc;
	logic         wr;
	logic [7:0]   wd;
	logic         running;
	logic         pol;
	logic [3:0]   mode;
	logic [1:0]   isel;
	logic         clk_tick;
	logic [6:0]   pre_lim;
	logic         pre_end;
	logic         count_en;
	logic         hit;
	logic         rise;
	logic         fall;
	logic         cap_edge;
	logic         pulse;
	logic         rld_ev;
	logic         cap_ev;
	logic [15:0]  cnt_inc;

	rtcp_in_filter u_filter (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_pin      (i_timer_in),
		.i_enable   (nfc_r[NFC_EN]),
		.i_sel      (nfc_r[NFC_SEL_HI:NFC_SEL_LO]),
		.o_level    (fin)
	);

	// avalon slave: one wait cycle, then the request is taken
	always_comb
	begin
		wait_nxt  = !((i_read || i_write) && wait_r);
		rdata_nxt = rdata_r;
		if (i_read && wait_r)
		begin
			case (i_address)
				REG_CNT_HI: rdata_nxt = cnt_r[15:8];
				REG_CNT_LO: rdata_nxt = running ? cnt_hold_r : cnt_r[7:0];
				REG_RLD_HI: rdata_nxt = rld_r[15:8];
				REG_RLD_LO: rdata_nxt = rld_r[7:0];
				REG_CHA_HI: rdata_nxt = cha_r[15:8];
				REG_CHA_LO: rdata_nxt = cha_r[7:0];
				REG_CHB_HI: rdata_nxt = chb_r[15:8];
				REG_CHB_LO: rdata_nxt = chb_r[7:0];
				REG_CTL0:   rdata_nxt = ctl0_r;
				REG_CTL1:   rdata_nxt = ctl1_r;
				REG_CTL2:   rdata_nxt = ctl2_r;
				REG_NFC:    rdata_nxt = nfc_r;
				default:    rdata_nxt = CTL_RESET;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wait_r  <= 1'b1;
			rdata_r <= CTL_RESET;
		end
		else
		begin
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// timer and register file
	always_comb
	begin
		acc      = (i_read || i_write) && !wait_r;
		wr       = i_write && acc && i_byteenable[0];
		wd       = i_writedata[7:0];
		running  = ctl1_r[CTL1_RUN];
		pol      = ctl1_r[CTL1_POL];
		mode     = {ctl0_r[CTL0_MODE_EXT], ctl1_r[CTL1_MODE_HI:0]};
		isel     = ctl0_r[CTL0_ISEL_HI:CTL0_ISEL_LO];
		// system clock or synchronised 32 kHz rising edges
		clk_tick = ctl2_r[CTL2_CLK_SEL] ? (sec_s2_r && !sec_prev_r)
			: 1'b1;
		pre_lim  = 7'((8'h01 << ctl1_r[CTL1_PRE_HI:CTL1_PRE_LO]) - 8'h01);
		pre_end  = (pre_r == pre_lim);
		count_en = running && clk_tick && pre_end && (run_r == RUN_COUNT);
		hit      = (cnt_r == rld_r);
		cnt_inc  = cnt_r + 16'h0001;
		rise     = fin && !in_prev_r;
		fall     = !fin && in_prev_r;
		cap_edge = ctl2_r[CTL2_DUAL_EDGE] ? (rise || fall)
			: (pol ? rise : fall);
		pulse    = 1'b0;
		rld_ev   = 1'b0;
		cap_ev   = 1'b0;

		cnt_nxt      = cnt_r;
		rld_nxt      = rld_r;
		rld_hold_nxt = rld_hold_r;
		cnt_hold_nxt = cnt_hold_r;
		cha_nxt      = cha_r;
		chb_nxt      = chb_r;
		ctl0_nxt     = ctl0_r;
		ctl1_nxt     = ctl1_r;
		ctl2_nxt     = ctl2_r;
		nfc_nxt      = nfc_r;
		pre_nxt      = pre_r;
		lvl_nxt      = lvl_r;
		run_nxt      = run_r;
		irq_nxt      = 1'b0;

		if (!running)
		begin
			pre_nxt = 7'h00;
			lvl_nxt = pol;
			run_nxt = (mode == MODE_TRIG || mode == MODE_DEMOD)
				? RUN_WAIT : RUN_COUNT;
		end
		else
		begin
			if (clk_tick)
				pre_nxt = pre_end ? 7'h00 : pre_r + 7'h01;
			if (count_en)
				cnt_nxt = hit ? CNT_RESTART : cnt_inc;
			rld_ev = count_en && hit;
			case (mode)
				MODE_TRIG:
				begin
					if (run_r == RUN_WAIT && (pol ? rise : fall))
						run_nxt = RUN_COUNT;
					pulse = rld_ev;
					if (rld_ev)
						run_nxt = RUN_WAIT;
				end
				MODE_CONT:
				begin
					if (rld_ev)
						lvl_nxt = !lvl_r;
				end
				MODE_PWM:
				begin
					if (rld_ev)
						lvl_nxt = pol;
					else if (count_en && cnt_inc == cha_r)
						lvl_nxt = !pol;
				end
				MODE_DEMOD:
				begin
					if (run_r == RUN_WAIT && (rise || fall))
						run_nxt = RUN_COUNT;
					if (run_r == RUN_COUNT && cap_edge)
					begin
						cap_ev = 1'b1;
						// falling edge goes to channel b in dual-edge use
						if (ctl2_r[CTL2_DUAL_EDGE] && fall)
							chb_nxt = cnt_r;
						else
							cha_nxt = cnt_r;
					end
				end
				default:
				begin
					cnt_nxt = cnt_r;
					rld_ev  = 1'b0;
				end
			endcase
			if (mode == MODE_DEMOD)
				irq_nxt = (isel == ISEL_CAP_ONLY) ? cap_ev
					: (isel == ISEL_RLD_ONLY) ? rld_ev
					: (cap_ev || rld_ev);
			else
				irq_nxt = rld_ev;
		end

		// high-byte read while running freezes the low byte for the following read
		if (i_read && wait_r && i_address == REG_CNT_HI && running)
			cnt_hold_nxt = cnt_r[7:0];

		if (wr)
		begin
			case (i_address)
				REG_CNT_HI: cnt_nxt[15:8] = wd;
				REG_CNT_LO: cnt_nxt[7:0]  = wd;
				REG_RLD_HI: rld_hold_nxt  = wd;
				REG_RLD_LO: rld_nxt       = {rld_hold_r, wd};
				REG_CHA_HI: cha_nxt[15:8] = wd;
				REG_CHA_LO: cha_nxt[7:0]  = wd;
				REG_CHB_HI: chb_nxt[15:8] = wd;
				REG_CHB_LO: chb_nxt[7:0]  = wd;
				REG_CTL0:   ctl0_nxt      = wd;
				REG_CTL1:   ctl1_nxt      = wd;
				REG_CTL2:   ctl2_nxt      = wd;
				REG_NFC:    nfc_nxt       = wd;
				default:    ctl0_nxt      = ctl0_r;
			endcase
		end

		// single-cycle pulse in one-shot, level otherwise
		tout_nxt = ctl2_r[CTL2_OUT_EN] &&
			((mode == MODE_TRIG) ? pulse : lvl_nxt);
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cnt_r      <= CNT_RESET;
			rld_r      <= WORD_RESET;
			rld_hold_r <= CTL_RESET;
			cnt_hold_r <= CTL_RESET;
			cha_r      <= WORD_RESET;
			chb_r      <= WORD_RESET;
			ctl0_r     <= CTL_RESET;
			ctl1_r     <= CTL_RESET;
			ctl2_r     <= CTL_RESET;
			nfc_r      <= CTL_RESET;
			pre_r      <= 7'h00;
			lvl_r      <= 1'b0;
			tout_r     <= 1'b0;
			irq_r      <= 1'b0;
			run_r      <= RUN_WAIT;
			in_prev_r  <= 1'b0;
			sec_s1_r   <= 1'b0;
			sec_s2_r   <= 1'b0;
			sec_prev_r <= 1'b0;
		end
		else
		begin
			cnt_r      <= cnt_nxt;
			rld_r      <= rld_nxt;
			rld_hold_r <= rld_hold_nxt;
			cnt_hold_r <= cnt_hold_nxt;
			cha_r      <= cha_nxt;
			chb_r      <= chb_nxt;
			ctl0_r     <= ctl0_nxt;
			ctl1_r     <= ctl1_nxt;
			ctl2_r     <= ctl2_nxt;
			nfc_r      <= nfc_nxt;
			pre_r      <= pre_nxt;
			lvl_r      <= lvl_nxt;
			tout_r     <= tout_nxt;
			irq_r      <= irq_nxt;
			run_r      <= run_nxt;
			in_prev_r  <= fin;
			sec_s1_r   <= i_sec_osc;
			sec_s2_r   <= sec_s1_r;
			sec_prev_r <= sec_s2_r;
		end
	end

	assign o_readdata    = {24'h000000, rdata_r};
	assign o_waitrequest = wait_r;
	assign o_timer_out   = tout_r;
	assign o_irq         = irq_r;
endmodule
`default_nettype wire

//--- rtcp_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rtcp_timer_checker
	import rtcp_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_rstn,
	input wire logic [5:0]  i_address,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0]  i_byteenable,
	input wire logic [31:0] o_readdata,
	input wire logic        o_waitrequest,
	input wire logic        o_timer_out,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	logic       acc;
	logic [7:0] c0_r, c1_r, c2_r, c0_nxt, c1_nxt, c2_nxt;
	logic [3:0] md;
	assign acc = i_write && !o_waitrequest && i_byteenable[0];
	assign md = {c0_r[CTL0_MODE_EXT], c1_r[2:0]};
	// shadow of the control bytes as the bus writes them
	always_comb
	begin
		c0_nxt = c0_r;
		c1_nxt = c1_r;
		c2_nxt = c2_r;
		if (acc && i_address == REG_CTL0)
			c0_nxt = i_writedata[7:0];
		if (acc && i_address == REG_CTL1)
			c1_nxt = i_writedata[7:0];
		if (acc && i_address == REG_CTL2)
			c2_nxt = i_writedata[7:0];
	end
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			c0_r <= CTL_RESET;
			c1_r <= CTL_RESET;
			c2_r <= CTL_RESET;
		end
		else
		begin
			c0_r <= c0_nxt;
			c1_r <= c1_nxt;
			c2_r <= c2_nxt;
		end
	end
	chk_irq_single: assert property (o_irq |=> !o_irq)
		else $error("irq wider than a cycle");
	chk_wait_ack: assert property ((i_read || i_write) && o_waitrequest
		|=> !o_waitrequest)
		else $error("no ack after one wait");
	chk_ack_once: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("ack held too long");
	chk_idle_wait: assert property (!(i_read || i_write) |-> o_waitrequest)
		else $error("ack while idle");
	chk_rd_upper: assert property (o_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_rd_hold: assert property (!(i_read && o_waitrequest)
		|=> $stable(o_readdata))
		else $error("read data moved");
	chk_shot_pulse: assert property (md == MODE_TRIG && $rose(o_timer_out)
		|=> !o_timer_out)
		else $error("one-shot pulse too wide");
	chk_cont_toggle: assert property (md == MODE_CONT && c1_r[CTL1_RUN]
		&& c2_r[CTL2_OUT_EN] && o_irq
		|-> o_timer_out != $past(o_timer_out))
		else $error("no toggle at reload");
	cov_read: cover property (i_read && !o_waitrequest);
	cov_irq: cover property (o_irq);
	cov_shot: cover property (md == MODE_TRIG && o_timer_out);
endmodule
bind rtcp_timer rtcp_timer_checker u_rtcp_timer_checker (.i_core_clk,
	.i_rstn, .i_address, .i_read, .i_write, .i_writedata, .i_byteenable,
	.o_readdata, .o_waitrequest, .o_timer_out, .o_irq);
`default_nettype wire

//--- test_reloadable_timer_capture_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module test_reloadable_timer_capture_pwm
	import rtcp_pkg::*;
;
`define CHK(nm, e, g) begin checked++; if ((e) !== (g)) begin \
	n_mismatch++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
	logic        i_core_clk = 1'b0, i_rstn = 1'b0, i_sec_osc = 1'b0;
	logic        i_read = 1'b0, i_write = 1'b0, pin_req = 1'b0;
	logic [5:0]  i_address = 6'h00;
	logic [31:0] i_writedata = 32'h0, o_readdata;
	logic [3:0]  i_byteenable = 4'h1;
	logic        o_waitrequest, i_timer_in, o_timer_out, o_irq;
	int          n_mismatch = 0, checked = 0, cyc = 0, nirq = 0;
	always #20 i_core_clk = ~i_core_clk;
	always #15260 i_sec_osc <= ~i_sec_osc;
	always @(posedge i_core_clk)
	begin
		cyc <= cyc + 1;
		if (o_irq === 1'b1)
			nirq <= nirq + 1;
	end
	rtcp_timer u_rtcp_timer (.i_core_clk, .i_rstn, .i_address, .i_read,
		.i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
		.i_timer_in, .i_sec_osc, .o_timer_out, .o_irq);
	rtcp_pin_model u_rtcp_pin_model (.i_core_clk, .i_rstn,
		.i_level(pin_req), .o_pin(i_timer_in));
	task automatic results;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tmo;
		n_mismatch++;
		$display("MISMATCH timeout exp 1 got 0");
		results;
	endtask
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		i_address <= a;
		i_writedata <= {24'h0, d};
		i_write <= w;
		i_read <= !w;
		@(posedge i_core_clk);
		while (o_waitrequest !== 1'b0)
		begin
			@(posedge i_core_clk);
			n++;
			if (n > 20)
				tmo;
		end
		q = o_readdata[7:0];
		i_write <= 1'b0;
		i_read <= 1'b0;
		@(posedge i_core_clk);
	endtask
	task automatic wr8(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic wr16(input logic [5:0] a, input logic [15:0] v);
		wr8(a, v[15:8]);
		wr8(a + 6'h04, v[7:0]);
	endtask
	task automatic rd16(input logic [5:0] a, output logic [15:0] v);
		bus(1'b0, a, 8'h00, v[15:8]);
		bus(1'b0, a + 6'h04, 8'h00, v[7:0]);
	endtask
	task automatic wsig(input logic sel, input logic v, output int n);
		n = 0;
		while ((sel ? o_timer_out : o_irq) !== v)
		begin
			@(posedge i_core_clk);
			n++;
			if (n > 9000)
				tmo;
		end
	endtask
	function automatic int per(int r, int p, logic s);
		return (r << p) * (s ? 763 : 1);
	endfunction
	task automatic cont(input int r, input int p, input logic s, input int tol);
		int   n;
		int   t[3];
		logic o[3];
		wr8(REG_CTL1, {2'b00, p[2:0], MODE_CONT[2:0]});
		wr8(REG_CTL2, {6'h00, 1'b1, s});
		wr8(REG_CTL0, 8'h00);
		wr16(REG_CNT_HI, 16'(1 + $urandom % r));
		wr16(REG_RLD_HI, 16'(r));
		wr8(REG_CTL1, {2'b10, p[2:0], MODE_CONT[2:0]});
		for (int i = 0; i < 3; i++)
		begin
			wsig(1'b0, 1'b1, n);
			t[i] = cyc;
			repeat (2) @(posedge i_core_clk);
			o[i] = o_timer_out;
		end
		for (int i = 1; i < 3; i++)
		begin
			n = t[i] - t[i - 1];
			if (n >= per(r, p, s) - tol && n <= per(r, p, s) + tol)
				n = per(r, p, s);
			`CHK("period", per(r, p, s), n)
			`CHK("toggle", !o[i - 1], o[i])
		end
		wr8(REG_CTL1, 8'h00);
	endtask
	task automatic pwm(input logic pol);
		int r, c, n;
		r = 8 + $urandom % 24;
		c = 2 + $urandom % (r - 2);
		wr8(REG_CTL1, {1'b0, pol, 3'h0, MODE_PWM[2:0]});
		wr8(REG_CTL2, 8'h02);
		wr16(REG_CNT_HI, 16'h0001);
		wr16(REG_CHA_HI, 16'(c));
		wr16(REG_RLD_HI, 16'(r));
		wr8(REG_CTL1, {1'b1, pol, 3'h0, MODE_PWM[2:0]});
		wsig(1'b1, !pol, n);
		wsig(1'b1, pol, n);
		wsig(1'b1, !pol, n);
		`CHK("pwm_on", c - 1, n)
		wsig(1'b1, pol, n);
		`CHK("pwm_off", r - c + 1, n)
		wr8(REG_CTL1, 8'h00);
	endtask
	task automatic shot;
		int r, n, k;
		r = 10 + $urandom % 40;
		wr8(REG_CTL1, {2'b01, 3'h0, MODE_TRIG[2:0]});
		wr16(REG_CNT_HI, 16'h0001);
		wr16(REG_RLD_HI, 16'(r));
		wr8(REG_CTL1, {2'b11, 3'h0, MODE_TRIG[2:0]});
		repeat (2)
		begin
			pin_req <= 1'b1;
			wsig(1'b1, 1'b1, n);
			`CHK("shot_at", 1'b1, n >= r - 1 && n <= r + 12)
			pin_req <= 1'b0;
			k = 0;
			repeat (3 * r)
			begin
				@(posedge i_core_clk);
				k += (o_timer_out !== 1'b0);
			end
			`CHK("shot_once", 0, k)
		end
		wr8(REG_CTL1, 8'h00);
	endtask
	task automatic demod(input logic dual, input logic pol,
		input logic [1:0] isel, input int e);
		int          n, k;
		logic [15:0] a, b;
		logic [7:0]  q;
		n = 20 + $urandom % 60;
		wr8(REG_CTL1, {1'b0, pol, 3'h0, MODE_DEMOD[2:0]});
		wr8(REG_CTL0, {MODE_DEMOD[3], 2'b00, isel, 3'h0});
		wr8(REG_CTL2, {3'h0, dual, 4'h0});
		wr8(REG_NFC, 8'ha0);
		wr16(REG_CNT_HI, 16'h0001);
		wr16(REG_RLD_HI, 16'hffff);
		wr16(REG_CHA_HI, 16'h0000);
		wr16(REG_CHB_HI, 16'h0000);
		wr8(REG_CTL1, {1'b1, pol, 3'h0, MODE_DEMOD[2:0]});
		repeat (30) @(posedge i_core_clk);
		rd16(REG_CNT_HI, a);
		`CHK("demod_idle", 16'h0001, a)
		for (int i = 0; i < 2; i++)
		begin
			k = nirq;
			pin_req <= 1'b1;
			repeat (i ? n : 20) @(posedge i_core_clk);
			pin_req <= 1'b0;
			repeat (30) @(posedge i_core_clk);
		end
		`CHK("demod_irq", e, nirq - k)
		rd16(REG_CNT_HI, a);
		bus(1'b0, REG_CNT_LO, 8'h00, q);
		`CHK("cnt_hold", a[7:0], q)
		rd16(REG_CHA_HI, a);
		rd16(REG_CHB_HI, b);
		if (dual)
			`CHK("capture", n, b - a)
		wr8(REG_CTL1, 8'h00);
		wr8(REG_CTL0, 8'h00);
	endtask
	initial
	begin
		logic [7:0] q, d;
		void'($urandom(32'hc4714e46));
		repeat (12) @(posedge i_core_clk);
		i_rstn <= 1'b1;
		@(posedge i_core_clk);
		for (int a = 0; a < 64; a += 4)
		begin
			bus(1'b0, 6'(a), 8'h00, q);
			`CHK("reset", (6'(a) == REG_CNT_LO) ? 8'h01 : 8'h00, q)
		end
		wr8(6'h30, 8'h5a);
		bus(1'b0, 6'h30, 8'h00, q);
		`CHK("unmapped", 8'h00, q)
		for (int a = 16; a < 32; a += 4)
		begin
			d = 8'($urandom);
			wr8(6'(a), d);
			bus(1'b0, 6'(a), 8'h00, q);
			`CHK("chan_rw", d, q)
		end
		wr8(REG_RLD_HI, 8'h5a);
		bus(1'b0, REG_RLD_HI, 8'h00, q);
		`CHK("rld_buffer", 8'h00, q)
		wr8(REG_RLD_LO, 8'ha5);
		bus(1'b0, REG_RLD_HI, 8'h00, q);
		`CHK("rld_commit", 8'h5a, q)
		repeat (3) cont(3 + $urandom % 20, $urandom % 4, 1'b0, 0);
		cont(3, 0, 1'b1, 2);
		pwm(1'b1);
		pwm(1'b0);
		shot;
		demod(1'b1, 1'b1, ISEL_CAP_ONLY, 2);
		demod(1'b0, 1'b0, ISEL_CAP_ONLY, 1);
		demod(1'b0, 1'b1, ISEL_RLD_ONLY, 0);
		demod(1'b1, 1'b0, 2'h0, 2);
		results;
	end
endmodule
`default_nettype wire
